// ### include/bus_ctl_pkg.sv
// ==========================================================
// bus addressing, commands and timing
// ==========================================================
package bus_ctl_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_DEFAULT = 5'h10;
    localparam logic [4:0] ADDR_MAX = 5'h1E;
    localparam int CMD_W = 7;
    // ==========================================================
    // command bytes seen with attention asserted
    // ==========================================================
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_UNL = 7'h3F;
    localparam logic [6:0] CMD_UNT = 7'h5F;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;
    // ==========================================================
    // timing
    // ==========================================================
    localparam longint CLK_HZ = 100000000;
    localparam longint ADDR_SHOW_MS = 1000;
    localparam longint ADDR_SHOW_CYCLES = (ADDR_SHOW_MS * CLK_HZ) / 1000;
    localparam int SHOW_CNT_W = 32;
    // ==========================================================
    // synchroniser bit positions
    // ==========================================================
    localparam int SY_ATN = 0;
    localparam int SY_REN = 1;
    localparam int SY_IFC = 2;
    localparam int SY_DAV = 3;
    localparam int SY_KEY = 4;
    localparam int SY_DIO = 5;
    localparam int SY_W = 13;
endpackage

// ### logic/sync_two_ff.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// two flip-flop level synchroniser
// ==========================================================
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // checked at elaboration so a zero width never builds
    if (WIDTH < 1) begin : g_bad_width
        $error("sync_two_ff width must be at least one");
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // sync_two_ff
`default_nettype wire

// ### logic/bus_remote_local.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// RL1: primary address is configurable 0 to 30; only matching addressing responds.
// RL2: address defaults to 16 until another is configured.
// RL3: system integrator keeps other bus addresses distinct from ours.
// RL4: after power-up the configured address is shown briefly.
// RL5: remote only after remote enable and then listen addressing.
// RL6: talking works in remote and local alike.
// RL7: in remote, front-panel keys are blocked except local key and power.
// RL8: local key in remote without lockout returns to local.
// RL9: interface clear sends talker and listener to idle.
// RL10: local lockout disables the local key.
// RL11: addressed go-to-local leaves remote for this device only.
// RL12: unaddressed release of remote also returns us to local.
// RL13: universal device clear resets the interface regardless of addressing.
// RL14: selective device clear does the same only when listen-addressed.
// RL15: in serial poll mode the status byte is sent when talking.
// RL16: after a query, talk addressing makes the response go out.
// RL17: controller should expect CR LF after each response.
// RL18: controller holds interface clear at least 100 microseconds.
// RL19: device clear empties buffers, cancels deferred commands, keeps settings.
// RL20: talker idle on untalk, own listen, clear; listener idle likewise.
// RL21: under lockout only go-to-local or release of remote enable restores the front panel.
// RL22: remote enable released leaves remote and clears lockout.
module bus_remote_local
    import bus_ctl_pkg::*;
#(
    parameter int KEYS_W = 8,
    parameter longint SHOW_CYCLES = bus_ctl_pkg::ADDR_SHOW_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic bus_atn,
    input wire logic bus_ren,
    input wire logic bus_ifc,
    input wire logic bus_dav,
    input wire logic [7:0] bus_dio,
    input wire logic local_key,
    input wire logic [KEYS_W-1:0] panel_keys,
    input wire logic addr_load,
    input wire logic [bus_ctl_pkg::ADDR_W-1:0] addr_cfg,
    input wire logic [7:0] poll_status,
    input wire logic resp_valid,
    input wire logic [7:0] resp_data,
    input wire logic talk_done,
    output logic [KEYS_W-1:0] panel_keys_out,
    output logic far_control_lamp,
    output logic listener_active_lamp,
    output logic talker_active_lamp,
    output logic lockout_lamp,
    output logic addr_show_lamp,
    output logic [bus_ctl_pkg::ADDR_W-1:0] addr_display,
    output logic listen_byte_valid,
    output logic [7:0] listen_byte,
    output logic dev_clear,
    output logic trigger,
    output logic resp_take,
    output logic talk_valid,
    output logic [7:0] talk_byte
);
    import bus_ctl_pkg::*;

    if (KEYS_W < 1 || SHOW_CYCLES < 1 ||
        SHOW_CYCLES >= (64'h1 << SHOW_CNT_W)) begin : g_bad_params
        $error("bus_remote_local parameters out of range");
    end

    localparam logic [SHOW_CNT_W-1:0] SHOW_LAST =
        SHOW_CNT_W'(SHOW_CYCLES - 1);

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    // dio travels with dav through equal stages; the controller
    // settles data before dav, so both arrive aligned enough
    logic [SY_W-1:0] pins_sync;

    sync_two_ff #(.WIDTH(SY_W)) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in({bus_dio, local_key, bus_dav, bus_ifc, bus_ren, bus_atn}),
        .sync_out(pins_sync)
    );

    logic atn_s, ren_s, ifc_s, dav_s, key_s;
    logic [7:0] dio_s;
    assign atn_s = pins_sync[SY_ATN];
    assign ren_s = pins_sync[SY_REN];
    assign ifc_s = pins_sync[SY_IFC];
    assign dav_s = pins_sync[SY_DAV];
    assign key_s = pins_sync[SY_KEY];
    assign dio_s = pins_sync[SY_DIO +: 8];

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic dav_prev;
        logic ren_prev;
        logic key_prev;
        logic listen;
        logic talk;
        logic remote;
        logic lockout;
        logic spoll;
        logic showing;
        logic [SHOW_CNT_W-1:0] show_cnt;
        logic [ADDR_W-1:0] addr;
        logic [KEYS_W-1:0] keys_out;
        logic lbyte_valid;
        logic [7:0] lbyte;
        logic clear;
        logic trig;
        logic take;
        logic tvalid;
        logic [7:0] tbyte;
    } state_type;

    state_type state_reg;
    state_type state_next;

    always_comb begin
        logic dav_rise;
        logic [CMD_W-1:0] cmd;
        logic my_listen;
        logic my_talk;
        dav_rise = dav_s & ~state_reg.dav_prev;
        cmd = dio_s[CMD_W-1:0];
        my_listen = cmd == {GRP_LISTEN, state_reg.addr}; // RL1
        my_talk = cmd == {GRP_TALK, state_reg.addr}; // RL1
        state_next = state_reg;
        state_next.dav_prev = dav_s;
        state_next.ren_prev = ren_s;
        state_next.key_prev = key_s;
        state_next.lbyte_valid = 1'b0;
        state_next.clear = 1'b0;
        state_next.trig = 1'b0;
        state_next.take = 1'b0;

        // address set-up; out-of-range values leave the old one
        if (addr_load && addr_cfg <= ADDR_MAX) begin
            state_next.addr = addr_cfg; // RL1
        end

        // ======================================================
        // power-up address display
        // ======================================================
        if (state_reg.showing) begin
            if (state_reg.show_cnt == SHOW_LAST) begin
                state_next.showing = 1'b0; // RL4
            end else begin
                state_next.show_cnt = state_reg.show_cnt + 1'b1;
            end
        end

        // ======================================================
        // bus bytes
        // ======================================================
        if (dav_rise && atn_s) begin
            if (my_listen) begin
                state_next.listen = 1'b1;
                state_next.talk = 1'b0; // RL20
                if (ren_s) begin
                    state_next.remote = 1'b1; // RL5
                end
            end else if (my_talk) begin
                state_next.talk = 1'b1; // RL6
                state_next.listen = 1'b0; // RL20
            end else if (cmd == CMD_UNL) begin
                state_next.listen = 1'b0; // RL20
            end else if (cmd == CMD_UNT) begin
                state_next.talk = 1'b0; // RL20
            end else if (cmd == CMD_LLO) begin
                state_next.lockout = 1'b1; // RL10
            end else if (cmd == CMD_GTL && state_reg.listen) begin
                state_next.remote = 1'b0; // RL11 RL21
            end else if (cmd == CMD_DCL ||
                         (cmd == CMD_SDC && state_reg.listen)) begin
                state_next.clear = 1'b1; // RL13 RL14
                state_next.tvalid = 1'b0; // RL19
            end else if (cmd == CMD_GET && state_reg.listen) begin
                state_next.trig = 1'b1;
            end else if (cmd == CMD_SPE) begin
                state_next.spoll = 1'b1; // RL15
            end else if (cmd == CMD_SPD) begin
                state_next.spoll = 1'b0; // RL15
            end
        end else if (dav_rise && state_reg.listen) begin
            state_next.lbyte_valid = 1'b1;
            state_next.lbyte = dio_s;
        end

        // ======================================================
        // talker
        // ======================================================
        if (talk_done) begin
            state_next.tvalid = 1'b0;
        end
        if (state_reg.talk && !atn_s && !state_reg.tvalid &&
            !state_reg.clear) begin
            if (state_reg.spoll) begin
                state_next.tvalid = 1'b1; // RL15
                state_next.tbyte = poll_status;
            end else if (resp_valid) begin
                state_next.tvalid = 1'b1; // RL16
                state_next.tbyte = resp_data;
                state_next.take = 1'b1; // RL16
            end
        end

        // ======================================================
        // local return and interface clear
        // ======================================================
        // a key press held across lockout release does not count
        if (key_s && !state_reg.key_prev && state_reg.remote &&
            !state_reg.lockout) begin
            state_next.remote = 1'b0; // RL8
        end
        if (!ren_s && state_reg.ren_prev) begin
            state_next.remote = 1'b0; // RL12 RL22
            state_next.lockout = 1'b0; // RL22
        end
        if (ifc_s) begin
            state_next.talk = 1'b0; // RL9
            state_next.listen = 1'b0; // RL9
            state_next.spoll = 1'b0;
            state_next.tvalid = 1'b0;
        end

        // panel keys follow the remote state just computed
        state_next.keys_out = state_next.remote ? '0 : panel_keys; // RL7
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
            state_reg.addr <= ADDR_DEFAULT; // RL2
            state_reg.showing <= 1'b1; // RL4
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign panel_keys_out = state_reg.keys_out;
    assign far_control_lamp = state_reg.remote;
    assign listener_active_lamp = state_reg.listen;
    assign talker_active_lamp = state_reg.talk;
    assign lockout_lamp = state_reg.lockout;
    assign addr_show_lamp = state_reg.showing;
    assign addr_display = state_reg.addr;
    assign listen_byte_valid = state_reg.lbyte_valid;
    assign listen_byte = state_reg.lbyte;
    assign dev_clear = state_reg.clear;
    assign trigger = state_reg.trig;
    assign resp_take = state_reg.take;
    assign talk_valid = state_reg.tvalid;
    assign talk_byte = state_reg.tbyte;
endmodule // bus_remote_local
`default_nettype wire

// ### tb/bus_remote_local_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// port checker for remote/local logic
module bus_remote_local_properties
    import bus_ctl_pkg::*;
#(
    parameter int KEYS_W = 8,
    parameter longint SHOW_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic bus_ifc,
    input wire logic [KEYS_W-1:0] panel_keys,
    input wire logic addr_load,
    input wire logic [bus_ctl_pkg::ADDR_W-1:0] addr_cfg,
    input wire logic [7:0] resp_data,
    input wire logic talk_done,
    input wire logic [KEYS_W-1:0] panel_keys_out,
    input wire logic far_control_lamp,
    input wire logic listener_active_lamp,
    input wire logic talker_active_lamp,
    input wire logic addr_show_lamp,
    input wire logic [bus_ctl_pkg::ADDR_W-1:0] addr_display,
    input wire logic dev_clear,
    input wire logic resp_take,
    input wire logic talk_valid,
    input wire logic [7:0] talk_byte
);
    // saturates so a long run cannot wrap it
    longint cnt_reg;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 0;
        end else if (cnt_reg < SHOW_CYCLES + 4) begin
            cnt_reg <= cnt_reg + 1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // two sync stages plus the acting edge
    sequence ifc_held;
        bus_ifc [*3];
    endsequence
    a_ifc_idle: assert property (ifc_held |=>
        !talker_active_lamp && !listener_active_lamp)
        else $error("talker or listener kept through clear");
    a_remote_listen: assert property ($rose(far_control_lamp)
        |-> listener_active_lamp) else $error("remote without listen");
    a_keys_blocked: assert property (far_control_lamp
        |-> panel_keys_out == '0) else $error("keys pass in remote");
    a_keys_pass: assert property (!far_control_lamp
        |-> panel_keys_out == $past(panel_keys))
        else $error("keys not passed in local");
    a_clear_pulse: assert property (dev_clear |=> !dev_clear)
        else $error("clear pulse too long");
    a_talk_cause: assert property ($rose(talk_valid)
        |-> $past(talker_active_lamp)) else $error("talk when not talker");
    a_resp_copy: assert property (resp_take
        |-> talk_valid && talk_byte == $past(resp_data))
        else $error("response byte not copied");
    a_done_clears: assert property (talk_done && talk_valid
        |=> !talk_valid) else $error("talk byte kept after done");
    a_addr_load: assert property (addr_load && addr_cfg <= ADDR_MAX
        |=> addr_display == $past(addr_cfg)) else $error("address not set");
    a_addr_refuse: assert property (addr_load && addr_cfg > ADDR_MAX
        |=> $stable(addr_display)) else $error("bad address taken");
    a_show_ends: assert property (cnt_reg > SHOW_CYCLES + 2
        |-> !addr_show_lamp) else $error("address shown too long");
endmodule // bus_remote_local_properties
bind bus_remote_local bus_remote_local_properties #(
    .KEYS_W(KEYS_W), .SHOW_CYCLES(SHOW_CYCLES)) u_props (
    .clk_sys, .rst_b, .bus_ifc, .panel_keys, .addr_load, .addr_cfg,
    .resp_data, .talk_done, .panel_keys_out, .far_control_lamp,
    .listener_active_lamp, .talker_active_lamp, .addr_show_lamp,
    .addr_display, .dev_clear, .resp_take, .talk_valid, .talk_byte);
`default_nettype wire

// ### tb/bus_host.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// bus controller model
module bus_host #(
    parameter int IFC_CYCLES = 10000
) (
    input wire logic clk_sys,
    output logic atn,
    output logic ren,
    output logic ifc,
    output logic dav,
    output logic [7:0] dio
);
    initial begin
        {atn, ren, ifc, dav} = 4'h0;
        dio = 8'hFF;
    end
    // one byte per dav rise, low and high at least three edges
    task automatic cmd(input logic a, input logic [7:0] b);
        @(posedge clk_sys);
        atn <= a;
        dio <= b;
        repeat (3) @(posedge clk_sys);
        dav <= 1'b1;
        repeat (4) @(posedge clk_sys);
        dav <= 1'b0;
        dio <= ~b;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic set_ren(input logic v);
        @(posedge clk_sys);
        ren <= v;
    endtask
    task automatic atn_low();
        @(posedge clk_sys);
        atn <= 1'b0;
    endtask
    task automatic pulse_ifc();
        @(posedge clk_sys);
        ifc <= 1'b1;
        repeat (IFC_CYCLES) @(posedge clk_sys);
        ifc <= 1'b0;
    endtask
endmodule // bus_host
`default_nettype wire

// ### tb/test_bus_remote_local.sv
`timescale 1ns/1ns
`default_nettype none
module test_bus_remote_local;
    import bus_ctl_pkg::*;
    localparam longint SHOW = 20;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic bus_atn, bus_ren, bus_ifc, bus_dav, lv, tk;
    logic [7:0] bus_dio, keys_o, lb, tb_byte;
    logic local_key = 1'b0, addr_load = 1'b0, resp_valid = 1'b0;
    logic talk_done = 1'b0;
    logic [7:0] panel_keys = 8'h00, poll_status = 8'h41;
    logic [7:0] resp_data = 8'h3C;
    logic [4:0] addr_cfg = 5'h00, addr_display;
    logic far, lis, tlk, lock, show, clr, trg, take;
    int errors = 0, n_checks = 0, n_clear = 0, n_trig = 0, n_data = 0;
    wire logic [7:0] lamps = {4'h0, far, lis, tlk, lock};
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (clr === 1'b1) n_clear++;
    always @(posedge clk_sys) if (trg === 1'b1) n_trig++;
    always @(posedge clk_sys) if (lv === 1'b1) n_data++;
    bus_host host (.clk_sys(clk_sys), .atn(bus_atn), .ren(bus_ren),
        .ifc(bus_ifc), .dav(bus_dav), .dio(bus_dio));
    bus_remote_local #(.SHOW_CYCLES(SHOW)) DUT (.clk_sys(clk_sys),
        .rst_b(rst_b), .bus_atn(bus_atn), .bus_ren(bus_ren),
        .bus_ifc(bus_ifc), .bus_dav(bus_dav), .bus_dio(bus_dio),
        .local_key(local_key), .panel_keys(panel_keys),
        .addr_load(addr_load), .addr_cfg(addr_cfg),
        .poll_status(poll_status), .resp_valid(resp_valid),
        .resp_data(resp_data), .talk_done(talk_done),
        .panel_keys_out(keys_o), .far_control_lamp(far),
        .listener_active_lamp(lis), .talker_active_lamp(tlk),
        .lockout_lamp(lock), .addr_show_lamp(show),
        .addr_display(addr_display), .listen_byte_valid(lv),
        .listen_byte(lb), .dev_clear(clr), .trigger(trg),
        .resp_take(take), .talk_valid(tk), .talk_byte(tb_byte));
    // ========
    // helpers
    task automatic chk(input string w, input logic [7:0] e,
            input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wait_for(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic key();
        @(posedge clk_sys);
        local_key <= 1'b1;
        repeat (4) @(posedge clk_sys);
        local_key <= 1'b0;
        wait_for(4);
    endtask
    // bounded so a dead talker cannot hang the run
    task automatic wait_talk();
        for (int i = 0; i < 20 && tk !== 1'b1; i++) wait_for(1);
        chk("talk_valid", 8'h01, {7'h00, tk});
        if (tk !== 1'b1) summarize();
        @(posedge clk_sys);
        resp_valid <= 1'b0;
        #1;
    endtask
    task automatic done();
        @(posedge clk_sys);
        talk_done <= 1'b1;
        @(posedge clk_sys);
        talk_done <= 1'b0;
        wait_for(2);
    endtask
    // one response byte: offered, loaded, compared, then sent
    task automatic take_resp(input logic [7:0] b);
        @(posedge clk_sys);
        resp_data <= b;
        resp_valid <= 1'b1;
        wait_talk();
        chk("talk_byte", b, tb_byte);
        done();
    endtask
    // ========
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        chk("addr", 8'h10, {3'h0, addr_display});
        chk("show", 8'h01, {7'h00, show});
        wait_for(SHOW + 4);
        chk("show", 8'h00, {7'h00, show});
        $display("test power_up done");
        host.set_ren(1'b1);
        wait_for(6);
        chk("lamps", 8'h00, lamps);
        host.cmd(1'b1, {1'b0, GRP_LISTEN, 5'h05});
        chk("lamps", 8'h00, lamps);
        host.cmd(1'b1, {1'b0, GRP_LISTEN, ADDR_DEFAULT});
        chk("lamps", 8'h0C, lamps);
        @(posedge clk_sys);
        panel_keys <= 8'hA5;
        wait_for(2);
        chk("keys", 8'h00, keys_o);
        key();
        chk("lamps", 8'h04, lamps);
        chk("keys", 8'hA5, keys_o);
        host.cmd(1'b1, {1'b0, GRP_LISTEN, ADDR_DEFAULT});
        host.cmd(1'b1, {1'b0, CMD_LLO});
        chk("lamps", 8'h0D, lamps);
        key();
        chk("lamps", 8'h0D, lamps);
        host.cmd(1'b1, {1'b0, CMD_GTL});
        chk("far", 8'h00, {7'h00, far});
        host.set_ren(1'b0);
        wait_for(6);
        chk("lamps", 8'h04, lamps);
        $display("test remote_local done");
        host.cmd(1'b1, {1'b0, CMD_SDC});
        chk("clears", 8'h01, 8'(n_clear));
        host.cmd(1'b1, {1'b0, CMD_GET});
        chk("triggers", 8'h01, 8'(n_trig));
        host.cmd(1'b0, 8'hA7);
        chk("listen_byte", 8'hA7, lb);
        chk("data_bytes", 8'h01, 8'(n_data));
        host.cmd(1'b1, {1'b0, CMD_UNL});
        chk("lamps", 8'h00, lamps);
        host.cmd(1'b0, 8'h5A);
        chk("data_bytes", 8'h01, 8'(n_data));
        host.cmd(1'b1, {1'b0, CMD_GET});
        chk("triggers", 8'h01, 8'(n_trig));
        host.cmd(1'b1, {1'b0, CMD_SDC});
        chk("clears", 8'h01, 8'(n_clear));
        host.cmd(1'b1, {1'b0, CMD_DCL});
        chk("clears", 8'h02, 8'(n_clear));
        $display("test clears done");
        host.cmd(1'b1, {1'b0, GRP_TALK, ADDR_DEFAULT});
        chk("lamps", 8'h02, lamps);
        host.atn_low();
        take_resp(8'h3C);
        chk("talk_valid", 8'h00, {7'h00, tk});
        // the response ends in carriage return then line feed
        take_resp(8'h0D);
        take_resp(8'h0A);
        host.cmd(1'b1, {1'b0, CMD_SPE});
        host.atn_low();
        wait_talk();
        chk("poll_byte", 8'h41, tb_byte);
        done();
        host.cmd(1'b1, {1'b0, CMD_SPD});
        host.cmd(1'b1, {1'b0, GRP_LISTEN, ADDR_DEFAULT});
        chk("lamps", 8'h04, lamps);
        host.cmd(1'b1, {1'b0, GRP_TALK, ADDR_DEFAULT});
        chk("lamps", 8'h02, lamps);
        host.pulse_ifc();
        wait_for(4);
        chk("lamps", 8'h00, lamps);
        $display("test talk done");
        @(posedge clk_sys);
        addr_cfg <= 5'h05;
        addr_load <= 1'b1;
        @(posedge clk_sys);
        addr_cfg <= 5'h1F;
        @(posedge clk_sys);
        addr_load <= 1'b0;
        wait_for(1);
        chk("addr", 8'h05, {3'h0, addr_display});
        host.cmd(1'b1, {1'b0, GRP_LISTEN, 5'h05});
        chk("lamps", 8'h04, lamps);
        $display("test address done");
        summarize();
    end
endmodule // test_bus_remote_local
`default_nettype wire
